// [lfd_pkg.sv]
/*
 Package for the long-form transfer descriptor decoder: doubleword
 indices, mode encodings, field widths and reset values.
 Assumes one 200 MHz clock and a synchronous active-low reset.
*/
package lfd_pkg;
	// doubleword indices within a descriptor (byte offset / 8)
	localparam logic [2:0] LFD_DW_LINK   = 3'h0;
	localparam logic [2:0] LFD_DW_ADDR   = 3'h1;
	localparam logic [2:0] LFD_DW_COUNT  = 3'h2;
	localparam logic [2:0] LFD_DW_CCOUNT = 3'h3;
	localparam logic [2:0] LFD_DW_BPITCH = 3'h4;
	localparam logic [2:0] LFD_DW_CPITCH = 3'h5;
	localparam logic [2:0] LFD_DW_VALUE  = 3'h6;
	localparam logic [2:0] LFD_DW_LAST   = 3'h7;
	localparam int         LFD_NUM_DW    = 8;
	localparam int         LFD_NUM_PAIRS = 46;
	// source modes
	typedef enum logic [2:0] {
		LFD_SRC_DIM   = 3'h0,
		LFD_SRC_FPDG  = 3'h1,
		LFD_SRC_FPOG  = 3'h2,
		LFD_SRC_FPOGL = 3'h3,
		LFD_SRC_VPDG  = 3'h4,
		LFD_SRC_VPOG  = 3'h5,
		LFD_SRC_FILL  = 3'h6,
		LFD_SRC_PWR   = 3'h7
	} lfd_src_t;
	// destination modes; codes 6 and 7 are illegal
	typedef enum logic [2:0] {
		LFD_DST_DIM  = 3'h0,
		LFD_DST_FPDG = 3'h1,
		LFD_DST_FPOG = 3'h2,
		LFD_DST_VPDG = 3'h3,
		LFD_DST_VPOG = 3'h4,
		LFD_DST_PRD  = 3'h5
	} lfd_dst_t;
	// access mode coding for colour / transparency use
	localparam logic [1:0] LFD_ACC_NORMAL = 2'h0;
	localparam logic [1:0] LFD_ACC_BLKWR  = 2'h1;
	localparam logic [1:0] LFD_ACC_TRANS0 = 2'h2;
	localparam logic [1:0] LFD_ACC_TRANS1 = 2'h3;
	localparam logic [31:0] LFD_WORD_RST  = 32'h0000_0000;
	localparam logic [63:0] LFD_DW_RST    = 64'h0000_0000_0000_0000;
	localparam logic        LFD_BIG_ENDIAN = 1'b0;
endpackage

// [lfd_half_split.sv]
/*
 Splits one descriptor doubleword into its source-side and
 destination-side 32-bit halves according to the endian mode.
 Assumes the endian mode is stable while a descriptor is loaded.
*/
module lfd_half_split (
	// doubleword in
	input  wire logic [63:0] dword_in,
	input  wire logic        little_in,
	// halves out
	output logic      [31:0] src_half_out,
	output logic      [31:0] dst_half_out
);
	// R6 source half selection
	assign src_half_out = little_in ? dword_in[31:0] : dword_in[63:32];
	assign dst_half_out = little_in ? dword_in[63:32] : dword_in[31:0];
endmodule // lfd_half_split

// [lfd_pair_check.sv]
/*
 Decides whether a source/destination mode pair is one of the
 supported long-form pairings and numbers it 1 to 46.
 Purely combinational; assumes nothing of its surroundings.
*/
module lfd_pair_check (
	// modes
	input  wire logic [2:0] src_mode_in,
	input  wire logic [2:0] dst_mode_in,
	// result
	output logic            legal_out,
	output logic      [5:0] pair_num_out
);
	wire logic memory_src;
	wire logic dst_known;
	wire logic [5:0] base;
	wire logic [5:0] src_wide;
	// widened first so the products never wrap at three bits
	assign src_wide   = {3'h0, src_mode_in};
	assign memory_src = src_mode_in < 3'(lfd_pkg::LFD_SRC_FILL);
	assign dst_known  = dst_mode_in <= 3'(lfd_pkg::LFD_DST_PRD);
	// R2 fill and peripheral-write pair with memory destinations only
	assign legal_out = dst_known &&
		(memory_src || dst_mode_in != 3'(lfd_pkg::LFD_DST_PRD));
	// numbering follows the 6-per-source then 5-per-source order
	assign base = memory_src ? src_wide * 6'h06
		: 6'h24 + (src_wide - 6'h06) * 6'h05;
	assign pair_num_out = legal_out ? 6'(base + 6'(dst_mode_in) + 6'h1) : 6'h00;
endmodule // lfd_pair_check

// [lfd_decoder.sv]
/*
 Long-form transfer descriptor decoder. Takes the eight doublewords of
 a descriptor as a stream, latches the endian mode at reset release,
 checks the mode pairing and presents the field words from flip-flops, with the mode flags decoded live.
 Assumes the memory side delivers doublewords 0..7 in order, one per
 valid strobe, from a 64-bit aligned descriptor_base.
*/
//
// Operation
// R1 - accept exactly 46 mode pairings
// R2 - eight sources; fill/peripheral-write need memory destinations
// R3 - value doubleword is colour only for block-write
// R4 - value doubleword is transparency only for transparency modes
// R5 - doubleword 0 holds next address and options
// R6 - eight doublewords, source half follows endian
// R7 - dimensioned source fields at 8..40
// R8 - fixed delta destination: entries and guide pointer
// R9 - offset-guided destination address is base
// R10 - variable delta destination ignores its counts
// R11 - variable offset destination: base, no counts
// R12 - peripheral-read destination fields are don't-care
// R13 - fixed delta source: entries and guide pointer
// R14 - endian latched from ready at reset release
// R15 - software aligns descriptor on 64 bits
// R16 - flag unsupported pairings
module lfd_decoder (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        reset_n_in,
	// endian strap
	input  wire logic        ready_strap_in,
	// mode selection
	input  wire logic [2:0]  src_mode_in,
	input  wire logic [2:0]  dst_mode_in,
	input  wire logic [1:0]  access_mode_in,
	// descriptor stream
	input  wire logic        dw_valid_in,
	input  wire logic [63:0] dw_data_in,
	output logic             dw_ready_out,
	// status
	output logic             little_endian_out,
	output logic             desc_done_out,
	output logic             pair_error_out,
	output logic [5:0]       pair_num_out,
	// decoded fields
	output logic [31:0]      next_entry_addr_out,
	output logic [31:0]      transfer_option_word_out,
	output logic [31:0]      src_addr_out,
	output logic             src_addr_is_base_out,
	output logic [31:0]      src_count_ba_out,
	output logic [31:0]      src_c_or_entries_out,
	output logic [31:0]      src_b_pitch_out,
	output logic [31:0]      src_c_pitch_or_guide_out,
	output logic             src_guided_out,
	output logic [31:0]      dst_addr_out,
	output logic             dst_addr_is_base_out,
	output logic             dst_counts_used_out,
	output logic [31:0]      dst_count_ba_out,
	output logic [31:0]      dst_c_or_entries_out,
	output logic [31:0]      dst_b_pitch_out,
	output logic [31:0]      dst_c_pitch_or_guide_out,
	output logic             dst_guided_out,
	output logic [63:0]      colour_value_out,
	output logic             colour_valid_out,
	output logic [63:0]      transp_value_out,
	output logic             transp_valid_out
);
	typedef enum logic [1:0] {
		LFD_ST_STRAP = 2'b00,
		LFD_ST_IDLE  = 2'b01,
		LFD_ST_LOAD  = 2'b10,
		LFD_ST_DONE  = 2'b11
	} lfd_state_t;

	localparam int LFD_NUM_DW_L = lfd_pkg::LFD_NUM_DW;

	lfd_state_t  state_r, state_nxt;
	logic [2:0]  dw_idx_r;
	logic        little_r;
	logic        done_r;
	logic        err_r;
	logic [5:0]  pair_r;
	// last doubleword is discarded, so only seven slots are kept
	logic [31:0] src_w_r [LFD_NUM_DW_L-1];
	logic [31:0] dst_w_r [LFD_NUM_DW_L-1];
	logic [63:0] value_r;

	wire logic [31:0] src_half;
	wire logic [31:0] dst_half;
	wire logic        pair_legal;
	wire logic [5:0]  pair_num;
	wire logic        take;
	wire logic        last_dw;
	wire logic        dst_prd;
	wire logic        src_guided;
	wire logic        dst_guided;
	wire logic        dst_base;
	wire logic        dst_var;

	lfd_half_split u_split (
		.dword_in     (dw_data_in),
		.little_in    (little_r),
		.src_half_out (src_half),
		.dst_half_out (dst_half)
	);

	lfd_pair_check u_pair (
		.src_mode_in  (src_mode_in),
		.dst_mode_in  (dst_mode_in),
		.legal_out    (pair_legal),
		.pair_num_out (pair_num)
	);

	function automatic logic is_guided_src(input logic [2:0] m);
		is_guided_src = m != 3'(lfd_pkg::LFD_SRC_DIM) && m < 3'(lfd_pkg::LFD_SRC_FILL);
	endfunction

	assign take     = dw_valid_in && dw_ready_out;
	assign last_dw  = dw_idx_r == lfd_pkg::LFD_DW_LAST;
	assign dst_prd  = dst_mode_in == 3'(lfd_pkg::LFD_DST_PRD);
	// R13 guided sources carry entries and guide pointer
	assign src_guided = is_guided_src(src_mode_in);
	// R8 guided destinations carry entries and guide pointer
	assign dst_guided = dst_mode_in != 3'(lfd_pkg::LFD_DST_DIM) && !dst_prd;
	// R9 offset-guided destination address is a base
	assign dst_base = dst_mode_in == 3'(lfd_pkg::LFD_DST_FPOG) ||
		dst_mode_in == 3'(lfd_pkg::LFD_DST_VPOG);
	// R10 variable-patch destinations have no counts
	assign dst_var = dst_mode_in == 3'(lfd_pkg::LFD_DST_VPDG) ||
		dst_mode_in == 3'(lfd_pkg::LFD_DST_VPOG);

	assign dw_ready_out = state_r == LFD_ST_LOAD;

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			LFD_ST_STRAP: state_nxt = LFD_ST_IDLE;
			LFD_ST_IDLE: begin
				if (dw_valid_in) begin
					state_nxt = LFD_ST_LOAD;
				end
			end
			LFD_ST_LOAD: begin
				if (take && last_dw) begin
					state_nxt = LFD_ST_DONE;
				end
			end
			LFD_ST_DONE: state_nxt = LFD_ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			state_r <= LFD_ST_STRAP;
		end else begin
			state_r <= state_nxt;
		end
	end

	// R14 endian caught on first clock after release
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			little_r <= lfd_pkg::LFD_BIG_ENDIAN;
		end else if (state_r == LFD_ST_STRAP) begin
			little_r <= ready_strap_in;
		end
	end

	// R6 stream index walks doublewords 0..7
	always_ff @(posedge clk_in) begin
		if (!reset_n_in || state_r != LFD_ST_LOAD) begin
			dw_idx_r <= lfd_pkg::LFD_DW_LINK;
		end else if (take) begin
			dw_idx_r <= dw_idx_r + 3'h1;
		end
	end

	// R6 halves stored per doubleword; last one is never stored
	genvar gi;
	generate
		for (gi = 0; gi < LFD_NUM_DW_L - 1; gi++) begin : g_store
			always_ff @(posedge clk_in) begin
				if (!reset_n_in) begin
					src_w_r[gi] <= lfd_pkg::LFD_WORD_RST;
					dst_w_r[gi] <= lfd_pkg::LFD_WORD_RST;
				end else if (take && dw_idx_r == 3'(gi)) begin
					src_w_r[gi] <= src_half;
					dst_w_r[gi] <= dst_half;
				end
			end
		end
	endgenerate

	// R3 value doubleword kept whole, not endian split
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			value_r <= lfd_pkg::LFD_DW_RST;
		end else if (take && dw_idx_r == lfd_pkg::LFD_DW_VALUE) begin
			value_r <= dw_data_in;
		end
	end

	// R16 pairing checked when the descriptor completes
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			done_r <= 1'b0;
			err_r  <= 1'b0;
			pair_r <= 6'h00;
		end else begin
			done_r <= take && last_dw;
			if (take && last_dw) begin
				err_r  <= !pair_legal;
				pair_r <= pair_num;
			end
		end
	end

	assign little_endian_out = little_r;
	assign desc_done_out     = done_r;
	// R1 only 46 pairings count as legal
	assign pair_error_out    = err_r;
	assign pair_num_out      = pair_r;

	// R5 doubleword 0: next entry address and option word
	assign next_entry_addr_out      = src_w_r[lfd_pkg::LFD_DW_LINK];
	assign transfer_option_word_out = dst_w_r[lfd_pkg::LFD_DW_LINK];
	// R7 source fields at fixed doubleword slots
	assign src_addr_out             = src_w_r[lfd_pkg::LFD_DW_ADDR];
	assign src_count_ba_out         = src_w_r[lfd_pkg::LFD_DW_COUNT];
	assign src_c_or_entries_out     = src_w_r[lfd_pkg::LFD_DW_CCOUNT];
	assign src_b_pitch_out          = src_w_r[lfd_pkg::LFD_DW_BPITCH];
	assign src_c_pitch_or_guide_out = src_w_r[lfd_pkg::LFD_DW_CPITCH];
	assign src_guided_out           = src_guided;
	assign src_addr_is_base_out     = src_mode_in == 3'(lfd_pkg::LFD_SRC_FPOG) ||
		src_mode_in == 3'(lfd_pkg::LFD_SRC_FPOGL) || src_mode_in == 3'(lfd_pkg::LFD_SRC_VPOG);
	// R12 peripheral-read destination fields forced to zero
	assign dst_addr_out             = dst_prd ? lfd_pkg::LFD_WORD_RST : dst_w_r[lfd_pkg::LFD_DW_ADDR];
	assign dst_addr_is_base_out     = dst_base;
	// R11 variable-patch counts dropped
	assign dst_counts_used_out      = !dst_var && !dst_prd;
	assign dst_count_ba_out         = dst_counts_used_out ? dst_w_r[lfd_pkg::LFD_DW_COUNT] : lfd_pkg::LFD_WORD_RST;
	assign dst_c_or_entries_out     = dst_prd ? lfd_pkg::LFD_WORD_RST : dst_w_r[lfd_pkg::LFD_DW_CCOUNT];
	assign dst_b_pitch_out          = dst_prd ? lfd_pkg::LFD_WORD_RST : dst_w_r[lfd_pkg::LFD_DW_BPITCH];
	assign dst_c_pitch_or_guide_out = dst_prd ? lfd_pkg::LFD_WORD_RST : dst_w_r[lfd_pkg::LFD_DW_CPITCH];
	assign dst_guided_out           = dst_guided;
	// R3 colour used only for block write
	assign colour_valid_out = access_mode_in == lfd_pkg::LFD_ACC_BLKWR && !dst_prd;
	assign colour_value_out = colour_valid_out ? value_r : lfd_pkg::LFD_DW_RST;
	// R4 transparency used only in transparency modes
	assign transp_valid_out = (access_mode_in == lfd_pkg::LFD_ACC_TRANS0 ||
		access_mode_in == lfd_pkg::LFD_ACC_TRANS1) && !dst_prd;
	assign transp_value_out = transp_valid_out ? value_r : lfd_pkg::LFD_DW_RST;

	property p_done_pulse;
		@(posedge clk_in) disable iff (!reset_n_in)
		(take && last_dw) |=> desc_done_out ##1 !desc_done_out;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done not a single pulse"); // R6

	property p_err;
		@(posedge clk_in) disable iff (!reset_n_in)
		(take && last_dw && !pair_legal) |=> pair_error_out && pair_num_out == 6'h00;
	endproperty
	a_err: assert property (p_err) else $error("illegal pairing not flagged"); // R16

	property p_legal_num;
		@(posedge clk_in) disable iff (!reset_n_in)
		desc_done_out && !pair_error_out |-> pair_num_out >= 6'h01 && pair_num_out <= 6'h2E;
	endproperty
	a_legal_num: assert property (p_legal_num) else $error("pair number out of range"); // R1

	property p_fill_prd;
		@(posedge clk_in) disable iff (!reset_n_in)
		(src_mode_in >= 3'(lfd_pkg::LFD_SRC_FILL) && dst_prd) |-> !pair_legal;
	endproperty
	a_fill_prd: assert property (p_fill_prd) else $error("fill to peripheral read accepted"); // R2

	property p_colour;
		@(posedge clk_in) disable iff (!reset_n_in)
		colour_valid_out |-> access_mode_in == lfd_pkg::LFD_ACC_BLKWR && colour_value_out == value_r;
	endproperty
	a_colour: assert property (p_colour) else $error("colour value misused"); // R3

	property p_transp;
		@(posedge clk_in) disable iff (!reset_n_in)
		transp_valid_out |-> access_mode_in[1] && !colour_valid_out;
	endproperty
	a_transp: assert property (p_transp) else $error("transparency misused"); // R4

	property p_link;
		@(posedge clk_in) disable iff (!reset_n_in)
		(take && dw_idx_r == lfd_pkg::LFD_DW_LINK) |=>
		next_entry_addr_out == (little_r ? $past(dw_data_in[31:0]) : $past(dw_data_in[63:32]));
	endproperty
	a_link: assert property (p_link) else $error("next entry address wrong half"); // R5

	property p_strap;
		@(posedge clk_in) disable iff (!reset_n_in)
		state_r != LFD_ST_STRAP |=> $stable(little_r);
	endproperty
	a_strap: assert property (p_strap) else $error("endian changed after reset"); // R14

	property p_prd_zero;
		@(posedge clk_in) disable iff (!reset_n_in)
		dst_prd |-> dst_addr_out == 32'h0000_0000 && !dst_counts_used_out;
	endproperty
	a_prd_zero: assert property (p_prd_zero) else $error("peripheral read address not zero"); // R12

	property p_var_counts;
		@(posedge clk_in) disable iff (!reset_n_in)
		dst_var |-> dst_count_ba_out == 32'h0000_0000 && dst_guided_out;
	endproperty
	a_var_counts: assert property (p_var_counts) else $error("variable-patch counts used"); // R10

	c_done: cover property (@(posedge clk_in) disable iff (!reset_n_in) desc_done_out && !pair_error_out);
	c_err: cover property (@(posedge clk_in) disable iff (!reset_n_in) desc_done_out && pair_error_out);
	c_little: cover property (@(posedge clk_in) disable iff (!reset_n_in) desc_done_out && little_r);
endmodule // lfd_decoder

// [lfd_desc_mem.sv]
/*
 Memory model holding one long-form descriptor and streaming it.
 Assumes the bench fills mem_r before pulsing start_in.
*/
module lfd_desc_mem (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        reset_n_in,
	// control from bench
	input  wire logic        start_in,
	input  wire logic        slow_in,
	// descriptor stream
	input  wire logic        dw_ready_in,
	output logic             dw_valid_out,
	output logic      [63:0] dw_data_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [63:0] mem_r [0:7];
	logic [2:0]  idx_r;
	logic        act_r;

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			dw_valid_out <= 1'b0;
			idx_r        <= 3'h0;
			act_r        <= 1'b0;
			dw_data_out  <= 64'h0;
		end else if (start_in) begin
			act_r        <= 1'b1;
			idx_r        <= 3'h0;
			dw_valid_out <= 1'b1;
			dw_data_out  <= mem_r[0];
		end else if (dw_valid_out && dw_ready_in) begin
			idx_r <= idx_r + 3'h1;
			// released bus must not keep the last value
			if (idx_r == 3'h7 || slow_in) begin
				dw_valid_out <= 1'b0;
				dw_data_out  <= ~dw_data_out;
				act_r        <= (idx_r != 3'h7);
			end else begin
				dw_data_out <= mem_r[idx_r + 3'h1];
			end
		end else if (act_r && !dw_valid_out) begin
			dw_valid_out <= 1'b1;
			dw_data_out  <= mem_r[idx_r];
		end else if (!dw_valid_out) begin
			dw_data_out <= ~dw_data_out;
		end
	end
endmodule // lfd_desc_mem

// [tb_top.sv]
/*
 Bench for the descriptor decoder: every mode pair in both endian modes.
 Assumes the memory model streams the table the bench writes.
*/
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin miscompares++; \
	$display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk = 1'b0, reset_n = 1'b0, strap = 1'b0, start = 1'b0, slow = 1'b0;
	logic [2:0]  src_m = 3'h0, dst_m = 3'h0;
	logic [1:0]  acc_m = 2'h0;
	logic        dw_valid, dw_ready, le_o, done, perr;
	logic [63:0] dw_data, cv, tv;
	logic [5:0]  pnum;
	logic [31:0] nxt, opt, sa, sba, sce, sbp, scp, da, dba, dce, dbp, dcp;
	logic        sbase, sguid, dbase, dused, dguid, cval, tval;
	int          miscompares = 0, compares = 0, cycles = 0;

	always #2.5 clk = ~clk;

	lfd_desc_mem mem (.clk_in(clk), .reset_n_in(reset_n), .start_in(start), .slow_in(slow),
		.dw_ready_in(dw_ready), .dw_valid_out(dw_valid), .dw_data_out(dw_data));

	lfd_decoder dut (.clk_in(clk), .reset_n_in(reset_n), .ready_strap_in(strap),
		.src_mode_in(src_m), .dst_mode_in(dst_m), .access_mode_in(acc_m),
		.dw_valid_in(dw_valid), .dw_data_in(dw_data), .dw_ready_out(dw_ready),
		.little_endian_out(le_o), .desc_done_out(done), .pair_error_out(perr),
		.pair_num_out(pnum), .next_entry_addr_out(nxt), .transfer_option_word_out(opt),
		.src_addr_out(sa), .src_addr_is_base_out(sbase), .src_count_ba_out(sba),
		.src_c_or_entries_out(sce), .src_b_pitch_out(sbp), .src_c_pitch_or_guide_out(scp),
		.src_guided_out(sguid), .dst_addr_out(da), .dst_addr_is_base_out(dbase),
		.dst_counts_used_out(dused), .dst_count_ba_out(dba), .dst_c_or_entries_out(dce),
		.dst_b_pitch_out(dbp), .dst_c_pitch_or_guide_out(dcp), .dst_guided_out(dguid),
		.colour_value_out(cv), .colour_valid_out(cval), .transp_value_out(tv),
		.transp_valid_out(tval));

	function automatic logic [31:0] wd(int k, int i, bit up);
		return {(up ? 8'hA5 : 8'h5A), 8'(k), 8'(i), 8'h3C};
	endfunction

	// source half is the upper word when big-endian
	function automatic logic [31:0] sh(int k, int i, bit le);
		return wd(k, i, !le);
	endfunction

	function automatic logic [31:0] dh(int k, int i, bit le);
		return wd(k, i, le);
	endfunction

	task automatic end_of_test;
		if (miscompares == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 6000) begin
			miscompares++;
			end_of_test();
		end
	end

	task automatic do_reset(bit e);
		@(posedge clk);
		reset_n <= 1'b0;
		strap   <= e;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge clk);
		// later strap changes must be ignored
		strap <= !e;
	endtask

	task automatic run_desc(int s, int d, bit le);
		int k, n, a, num;
		bit lg, sm;
		logic [63:0] w6;
		k = s * 8 + d;
		a = k % 4;
		n = 0;
		lg = (s < 6 && d < 6) || (s >= 6 && d < 5);
		num = !lg ? 0 : (s < 6 ? s * 6 + d + 1 : (s == 6 ? 37 + d : 42 + d));
		sm = k[2];
		w6 = {wd(k, 6, 1), wd(k, 6, 0)};
		@(posedge clk);
		src_m <= 3'(s);
		dst_m <= 3'(d);
		acc_m <= 2'(a);
		slow  <= sm;
		for (int i = 0; i < 8; i++)
			mem.mem_r[i] = {wd(k, i, 1), wd(k, i, 0)};
		// peripheral-read destination address word is zero
		if (d == 5)
			mem.mem_r[1] = le ? {32'h0, wd(k, 1, 0)} : {wd(k, 1, 1), 32'h0};
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (done !== 1'b1 && n < 60);
		`CHK(done, 1'b1)
		`CHK(le_o, le)
		`CHK(perr, !lg)
		`CHK(pnum, 6'(num))
		if (lg) begin
			`CHK(nxt, sh(k, 0, le))
			`CHK(opt, dh(k, 0, le))
			`CHK(cval, a == 1 && d != 5)
			`CHK(tval, a >= 2 && d != 5)
			`CHK(cv, (a == 1 && d != 5) ? w6 : 64'h0)
			`CHK(tv, (a >= 2 && d != 5) ? w6 : 64'h0)
			`CHK(sguid, s inside {[1:5]})
			`CHK(sbase, s inside {2, 3, 5})
			`CHK(dguid, d inside {[1:4]})
			`CHK(dbase, d inside {2, 4})
			`CHK(dused, d inside {[0:2]})
			if (s < 6) begin
				`CHK(sa, sh(k, 1, le))
				`CHK(sba, sh(k, 2, le))
				`CHK(sce, sh(k, 3, le))
				`CHK(sbp, sh(k, 4, le))
				`CHK(scp, sh(k, 5, le))
			end
			if (d < 5) begin
				`CHK(da, dh(k, 1, le))
				`CHK(dce, dh(k, 3, le))
				`CHK(dbp, dh(k, 4, le))
				`CHK(dcp, dh(k, 5, le))
			end
			if (d < 3)
				`CHK(dba, dh(k, 2, le))
			else
				`CHK(dba, 32'h0000_0000)
			if (d == 5)
				`CHK(da, 32'h0000_0000)
		end
		@(posedge clk);
		#1;
		`CHK(done, 1'b0)
	endtask

	initial begin
		for (int e = 0; e < 2; e++) begin
			do_reset(e[0]);
			for (int s = 0; s < 8; s++)
				for (int d = 0; d < 8; d++)
					run_desc(s, d, e[0]);
		end
		end_of_test();
	end
endmodule // tb_top
